/* File: hdl/can_gc_pkg.sv */
`default_nettype none
package can_gc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_TT_CAPTURE = 8'h08;

  localparam int BIT_OVERLOAD = 6;
  localparam int BIT_TT_SELECT = 5;
  localparam int BIT_SYNC_POINT = 4;
  localparam int BIT_LISTEN = 3;
  localparam int BIT_TEST = 2;
  localparam int BIT_ENABLE = 1;
  localparam int BIT_SOFT_RESET = 0;

  localparam int STAT_RUNNING = 0;
  localparam int STAT_CLK_RUN = 1;
  localparam int STAT_DRAINING = 2;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'h7e;
  localparam logic [15:0] TT_CAPTURE_RESET = 16'h0000;
  localparam logic [1:0] START_DELAY_CYCLES = 2'h2;
  localparam logic RECESSIVE = 1'b1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SEL_NONE = 2'h0,
    SEL_CONTROL = 2'h1,
    SEL_STATUS = 2'h2,
    SEL_TT_CAPTURE = 2'h3
  } reg_sel_t;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_DRAIN = 4'b0010,
    ST_START = 4'b0100,
    ST_RUN = 4'b1000
  } run_state_t;

  typedef struct packed {
    logic frame_busy;
    logic sof;
    logic eof_last_bit;
    logic ovl_tx_start;
    logic tx_bit;
    logic [15:0] tt_timer;
  } engine_in_t;

  typedef struct packed {
    logic overload_request;
    logic tt_mode;
    logic sync_point;
    logic listen_mode;
    logic test_mode;
    logic clk_run;
    logic fsm_run;
    logic rx_enable;
    logic ctrl_reset;
  } control_out_t;
endpackage : can_gc_pkg
`default_nettype wire

/* File: hdl/pin_sync.sv */
`default_nettype none
module pin_sync
  import can_gc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic synced
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = pin;
    sync_d = meta_q;
  end

  // idle bus level so a reset does not fake a dominant bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= RECESSIVE;
      sync_q <= RECESSIVE;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign synced = sync_q;
endmodule : pin_sync
`default_nettype wire

/* File: hdl/run_sequencer.sv */
`default_nettype none
module run_sequencer
  import can_gc_pkg::*;
(
  input wire logic aclk,
  input wire logic ctl_rst_n,
  input wire logic enable_req,
  input wire logic frame_busy,
  output run_state_t state
);
  run_state_t state_q;
  run_state_t state_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      ST_OFF: begin
        if (enable_req) begin
          state_d = ST_START; // R10
          cnt_d = START_DELAY_CYCLES - 2'h1;
        end
      end
      ST_START: begin
        if (!enable_req) begin
          state_d = frame_busy ? ST_DRAIN : ST_OFF;
        end else if (cnt_q == 2'h0) begin
          state_d = ST_RUN; // R10
        end else begin
          cnt_d = cnt_q - 2'h1;
        end
      end
      ST_RUN: begin
        if (!enable_req) begin
          state_d = frame_busy ? ST_DRAIN : ST_OFF; // R7
        end
      end
      ST_DRAIN: begin
        // re-enabled while draining: start once the frame ends, straight from drain so the clock never gaps
        if (!frame_busy && enable_req) begin
          state_d = ST_START; // R6 R10
          cnt_d = START_DELAY_CYCLES - 2'h1;
        end else if (!frame_busy) begin
          state_d = ST_OFF; // R7
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!ctl_rst_n) begin
      state_q <= ST_OFF; // R12
      cnt_q <= 2'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign state = state_q;
endmodule : run_sequencer
`default_nettype wire

/* File: hdl/can_general_control.sv */
// What this block does
// R1: overload request set by software, cleared at overload start
// R2: time-trigger select enables time-triggered operation
// R3: sync point picks capture at EOF or SOF
// R4: listen-mode bit switches listening mode
// R5: software keeps the test bit cleared
// R6: enable bit runs controller and its clock
// R7: disable finishes frame, then freezes; objects untouched
// R8: standby: tx recessive, receiver off, clock stopped
// R9: registers stay accessible while disabled
// R10: two clock periods before state machine runs
// R11: soft reset acts like hardware reset, combined
// R12: after reset disabled, all control bits zero
// R13: soft reset bit clears one cycle later
`default_nettype none
module can_general_control
  import can_gc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic can_rx,
  output logic can_tx,
  output logic rx_to_engine,
  input wire engine_in_t eng,
  output control_out_t ctrl
);
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr == ADDR_CONTROL) begin
      sel = SEL_CONTROL;
    end else if (addr == ADDR_STATUS) begin
      sel = SEL_STATUS;
    end else if (addr == ADDR_TT_CAPTURE) begin
      sel = SEL_TT_CAPTURE;
    end
    return sel;
  endfunction : decode
  // bus slave state
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [7:0] w_byte_q, w_byte_d;
  logic w_lane_q, w_lane_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic write_fire;
  reg_sel_t wsel;
  // control state
  logic [7:0] ctrl_q, ctrl_d;
  logic soft_rst_q, soft_rst_d;
  logic [15:0] tt_cap_q, tt_cap_d;
  logic tx_q, tx_d;
  logic rx_q, rx_d;
  logic reset_out_q, reset_out_d;
  logic ctl_rst_n;
  logic rx_sync;
  logic standby;
  logic capture_event;
  run_state_t run_state;
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    aw_addr_d = aw_addr_q;
    w_byte_d = w_byte_q;
    w_lane_d = w_lane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    write_fire = 1'b0;
    wsel = decode(aw_addr_q);
    if (awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_have_d = 1'b1;
      w_byte_d = wdata[7:0];
      w_lane_d = wstrb[0];
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_have_q && w_have_q && !bvalid_q) begin
      write_fire = 1'b1;
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_addr_q <= aw_addr_d;
      w_byte_q <= w_byte_d;
      w_lane_q <= w_lane_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  // reads answer one cycle after the address is taken, whatever the run state
  always_comb begin
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready_q) begin
      rvalid_d = 1'b1; // R9
      rresp_d = RESP_OKAY;
      unique case (decode(araddr))
        SEL_CONTROL: rdata_d = {24'h000000, ctrl_q[7:1], soft_rst_q};
        SEL_STATUS: rdata_d = {29'h0, run_state == ST_DRAIN, !standby, run_state == ST_RUN};
        SEL_TT_CAPTURE: rdata_d = {16'h0000, tt_cap_q};
        SEL_NONE: begin
          rdata_d = 32'h00000000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // bus logic is outside the combined reset so the response still completes
  assign ctl_rst_n = aresetn && !soft_rst_q; // R11
  assign standby = (run_state == ST_OFF);
  assign capture_event = ctrl_q[BIT_SYNC_POINT] ? eng.eof_last_bit : eng.sof; // R3

  always_comb begin
    ctrl_d = ctrl_q;
    soft_rst_d = 1'b0; // R13
    tt_cap_d = tt_cap_q;
    if (eng.ovl_tx_start) begin
      ctrl_d[BIT_OVERLOAD] = 1'b0; // R1
    end
    if (write_fire && wsel == SEL_CONTROL && w_lane_q) begin
      if (w_byte_q[BIT_SOFT_RESET]) begin
        soft_rst_d = 1'b1; // R11
      end else begin
        ctrl_d = w_byte_q & CONTROL_WMASK; // R9
        // a new request written in the cycle of the overload start survives
        if (eng.ovl_tx_start && !w_byte_q[BIT_OVERLOAD]) begin
          ctrl_d[BIT_OVERLOAD] = 1'b0; // R1
        end
      end
    end
    if (ctrl_q[BIT_TT_SELECT] && capture_event) begin
      tt_cap_d = eng.tt_timer; // R2 R3
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= soft_rst_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!ctl_rst_n) begin
      ctrl_q <= CONTROL_RESET; // R12
      tt_cap_q <= TT_CAPTURE_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      tt_cap_q <= tt_cap_d;
    end
  end

  always_comb begin
    tx_d = standby ? RECESSIVE : eng.tx_bit; // R8
    rx_d = standby ? RECESSIVE : rx_sync; // R8
    reset_out_d = soft_rst_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_q <= RECESSIVE;
      rx_q <= RECESSIVE;
      reset_out_q <= 1'b1;
    end else begin
      tx_q <= tx_d;
      rx_q <= rx_d;
      reset_out_q <= reset_out_d; // R11
    end
  end

  pin_sync u_rx_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(can_rx),
    .synced(rx_sync)
  );

  // object enables live elsewhere and are never touched on disable
  run_sequencer u_seq (
    .aclk(aclk),
    .ctl_rst_n(ctl_rst_n),
    .enable_req(ctrl_q[BIT_ENABLE]), // R6
    .frame_busy(eng.frame_busy), // R7
    .state(run_state)
  );

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign can_tx = tx_q;
  assign rx_to_engine = rx_q;
  // test bit is only stored; the application is expected to leave it zero
  assign ctrl.overload_request = ctrl_q[BIT_OVERLOAD]; // R1
  assign ctrl.tt_mode = ctrl_q[BIT_TT_SELECT]; // R2
  assign ctrl.sync_point = ctrl_q[BIT_SYNC_POINT];
  assign ctrl.listen_mode = ctrl_q[BIT_LISTEN]; // R4
  assign ctrl.test_mode = ctrl_q[BIT_TEST]; // R5
  assign ctrl.clk_run = run_state[1] | run_state[2] | run_state[3]; // R6 R8
  assign ctrl.fsm_run = run_state[3]; // R10
  assign ctrl.rx_enable = ~run_state[0]; // R8
  assign ctrl.ctrl_reset = reset_out_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_ovl_clear;
    ctrl.overload_request && eng.ovl_tx_start && !write_fire |=> !ctrl.overload_request;
  endproperty
  a_ovl_clear: assert property (p_ovl_clear) else $error("overload request not cleared"); // R1
  property p_tt_off;
    !ctrl.tt_mode && !soft_rst_q |=> $stable(tt_cap_q);
  endproperty
  a_tt_off: assert property (p_tt_off) else $error("capture outside time-trigger mode"); // R2
  property p_tt_eof;
    ctrl.tt_mode && ctrl.sync_point && eng.eof_last_bit && !soft_rst_q |=> tt_cap_q == $past(eng.tt_timer);
  endproperty
  a_tt_eof: assert property (p_tt_eof) else $error("timer not caught at end of frame"); // R3
  property p_tt_sof;
    ctrl.tt_mode && !ctrl.sync_point && eng.sof && !soft_rst_q |=> tt_cap_q == $past(eng.tt_timer);
  endproperty
  a_tt_sof: assert property (p_tt_sof) else $error("timer not caught at start of frame"); // R3
  property p_listen;
    $rose(ctrl.listen_mode) |-> $past(write_fire) && $past(w_byte_q[BIT_LISTEN]);
  endproperty
  a_listen: assert property (p_listen) else $error("listen mode without a write"); // R4
  property p_run_clock;
    $past(ctrl_q[BIT_ENABLE]) && ctrl_q[BIT_ENABLE] |-> ctrl.clk_run && ctrl.rx_enable;
  endproperty
  a_run_clock: assert property (p_run_clock) else $error("running without clock"); // R6
  property p_drain;
    ctrl.fsm_run && !ctrl_q[BIT_ENABLE] && eng.frame_busy && ctl_rst_n |=> ctrl.clk_run && !ctrl.fsm_run;
  endproperty
  a_drain: assert property (p_drain) else $error("frame not finished on disable"); // R7
  property p_standby;
    standby ##1 standby |-> can_tx == RECESSIVE && rx_to_engine == RECESSIVE && !ctrl.clk_run;
  endproperty
  a_standby: assert property (p_standby) else $error("standby outputs wrong"); // R8
  property p_disabled_write;
    write_fire && standby && wsel == SEL_CONTROL && w_lane_q && !w_byte_q[BIT_SOFT_RESET] && !eng.ovl_tx_start
      |=> ctrl_q == ($past(w_byte_q) & CONTROL_WMASK);
  endproperty
  a_disabled_write: assert property (p_disabled_write) else $error("write lost while disabled"); // R9
  property p_start_delay;
    $rose(ctrl.fsm_run) |-> $past(run_state == ST_START) && $past(run_state == ST_START, 2);
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("start delay not two cycles"); // R10
  property p_soft_reset;
    soft_rst_q |=> ctrl_q == CONTROL_RESET && standby && tt_cap_q == TT_CAPTURE_RESET;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete"); // R11 R12
  property p_soft_clear;
    soft_rst_q |=> !soft_rst_q ##1 !ctrl.ctrl_reset;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft reset bit stuck"); // R13
  c_start: cover property (ctrl_q[BIT_ENABLE] ##[1:4] ctrl.fsm_run);
  c_drain: cover property (run_state == ST_DRAIN ##[1:20] standby);
  c_ovl: cover property (ctrl.overload_request ##[1:50] eng.ovl_tx_start);
  c_soft: cover property (write_fire && soft_rst_d);
endmodule : can_general_control
`default_nettype wire

/* File: dv/can_bus_node.sv */
`default_nettype none
module can_bus_node
  import can_gc_pkg::*;
(
  input wire logic aclk,
  input wire logic can_tx,
  output logic can_rx,
  output engine_in_t eng
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drive_q;
  // wired-and bus with pull-up: recessive unless someone drives dominant
  assign can_rx = can_tx & drive_q;
  initial begin
    drive_q = 1'b1;
    eng = '0;
    eng.tx_bit = 1'b1;
  end
  // kind 0 start of frame, 1 last eof bit, 2 overload start; one cycle each
  task automatic pulse(input int kind, input logic [15:0] t);
    eng.tt_timer <= t;
    eng.sof <= (kind == 0);
    eng.eof_last_bit <= (kind == 1);
    eng.ovl_tx_start <= (kind == 2);
    @(posedge aclk);
    eng.sof <= 1'b0;
    eng.eof_last_bit <= 1'b0;
    eng.ovl_tx_start <= 1'b0;
    // timer moves on, so a late capture shows a wrong value
    eng.tt_timer <= ~t;
    // one quiet edge so back-to-back pulses never drive twice in one step
    @(posedge aclk);
  endtask : pulse
  task automatic busy(input logic b);
    eng.frame_busy <= b;
    drive_q <= ~b;
  endtask : busy
endmodule : can_bus_node
`default_nettype wire

/* File: dv/can_general_control_test.sv */
`default_nettype none
module can_general_control_test;
  import can_gc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic can_rx, can_tx, rx_to_engine;
  engine_in_t eng;
  control_out_t ctrl;
  int error_cnt, checks_done, cyc, n;

  can_general_control dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .can_rx(can_rx), .can_tx(can_tx),
    .rx_to_engine(rx_to_engine), .eng(eng), .ctrl(ctrl));
  can_bus_node node (.aclk(aclk), .can_tx(can_tx), .can_rx(can_rx), .eng(eng));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // generous ceiling: the whole sequence needs under two hundred cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic idle(input int k);
    repeat (k) @(posedge aclk);
  endtask : idle
  // software keeps the test bit cleared in every control register write below
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
  endtask : wr
  task automatic rdw(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
  endtask : rdw

  task automatic t_reset;
    rdw(ADDR_CONTROL);
    chk(rd, 32'(CONTROL_RESET));
    chk({ctrl.clk_run, ctrl.fsm_run, ctrl.rx_enable}, 3'h0);
    chk(can_tx, RECESSIVE);
    $display("reset test done");
  endtask : t_reset
  task automatic t_modes;
    wr(ADDR_CONTROL, 32'h0000_0038);
    rdw(ADDR_CONTROL);
    chk(rd, 32'h0000_0038);
    chk({ctrl.tt_mode, ctrl.sync_point, ctrl.listen_mode, ctrl.test_mode}, 4'he);
    wr(ADDR_CONTROL, 32'h0000_0000);
    idle(1);
    chk({ctrl.tt_mode, ctrl.listen_mode}, 2'h0);
    $display("mode test done");
  endtask : t_modes
  task automatic t_enable;
    node.eng.tx_bit <= 1'b0;
    wr(ADDR_CONTROL, 32'h0000_0002);
    chk(ctrl.fsm_run, 1'b0);
    n = 0;
    while (ctrl.fsm_run !== 1'b1 && n < 10) begin
      idle(1);
      n++;
    end
    chk(n, 32'd3);
    chk(ctrl.clk_run, 1'b1);
    chk(can_tx, 1'b0);
    rdw(ADDR_STATUS);
    chk(rd, 32'h0000_0003);
    chk(rx_to_engine, 1'b0);
    node.eng.tx_bit <= 1'b1;
    $display("enable test done");
  endtask : t_enable
  task automatic t_capture;
    wr(ADDR_CONTROL, 32'h0000_0022);
    node.pulse(1, 16'h1111);
    node.pulse(0, 16'h2222);
    rdw(ADDR_TT_CAPTURE);
    chk(rd, 32'h0000_2222);
    wr(ADDR_CONTROL, 32'h0000_0032);
    node.pulse(0, 16'h3333);
    node.pulse(1, 16'h4444);
    rdw(ADDR_TT_CAPTURE);
    chk(rd, 32'h0000_4444);
    wr(ADDR_CONTROL, 32'h0000_0002);
    node.pulse(0, 16'h5555);
    rdw(ADDR_TT_CAPTURE);
    chk(rd, 32'h0000_4444);
    $display("capture test done");
  endtask : t_capture
  task automatic t_overload;
    wr(ADDR_CONTROL, 32'h0000_0042);
    chk(ctrl.overload_request, 1'b1);
    node.pulse(2, 16'h0000);
    idle(2);
    chk(ctrl.overload_request, 1'b0);
    rdw(ADDR_CONTROL);
    chk(rd, 32'h0000_0002);
    $display("overload test done");
  endtask : t_overload
  task automatic t_standby;
    node.busy(1'b1);
    node.eng.tx_bit <= 1'b0;
    wr(ADDR_CONTROL, 32'h0000_0000);
    idle(2);
    chk({ctrl.clk_run, ctrl.fsm_run}, 2'h2);
    rdw(ADDR_STATUS);
    chk(rd, 32'h0000_0006);
    wr(ADDR_CONTROL, 32'h0000_0008);
    rdw(ADDR_CONTROL);
    chk(rd, 32'h0000_0008);
    node.busy(1'b0);
    idle(3);
    chk(ctrl.clk_run, 1'b0);
    chk(can_tx, RECESSIVE);
    node.drive_q <= 1'b0;
    idle(5);
    chk({rx_to_engine, ctrl.rx_enable}, 2'h2);
    node.drive_q <= 1'b1;
    node.eng.tx_bit <= 1'b1;
    $display("standby test done");
  endtask : t_standby
  task automatic t_soft;
    wr(ADDR_CONTROL, 32'h0000_002a);
    idle(4);
    wr(ADDR_CONTROL, 32'h0000_0001);
    idle(1);
    chk(ctrl.ctrl_reset, 1'b1);
    idle(1);
    chk(ctrl.ctrl_reset, 1'b0);
    rdw(ADDR_CONTROL);
    chk(rd, 32'h0000_0000);
    chk({ctrl.tt_mode, ctrl.listen_mode, ctrl.clk_run, ctrl.fsm_run}, 4'h0);
    rdw(ADDR_STATUS);
    chk(rd, 32'h0000_0000);
    $display("soft reset test done");
  endtask : t_soft
  task automatic t_unmapped;
    rdw(8'h0c);
    chk(rs, RESP_SLVERR);
    chk(rd, 32'h0);
    wr(8'h0c, 32'h0000_00ff);
    chk(rs, RESP_SLVERR);
    $display("unmapped test done");
  endtask : t_unmapped

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_modes();
    t_enable();
    t_capture();
    t_overload();
    t_standby();
    t_soft();
    t_unmapped();
    wrap_up();
  end
endmodule : can_general_control_test
`default_nettype wire
